// >>> spm_baud.sv
`timescale 1ns/1ps
`include "spm_consts.svh"
module spm_baud (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// configuration and ticks
	spm_baud_if.gen bif
);

	localparam logic [3:0] M0_HALF_LAST = 4'(`SPM_M0_DIV / 2 - 1);

	logic [9:0] rl_cnt;
	logic rl_ovf;
	logic src;
	logic [1:0] pre_cnt;
	logic [1:0] pre_last;
	logic [3:0] half_cnt;

	// ----------------------------------------
	// rate source selection
	// ----------------------------------------
	assign rl_ovf = (rl_cnt == `SPM_RELOAD_TOP);
	// [R11] reload or timer source
	assign src = bif.fixed_rate ? 1'b1 : (bif.use_reload ? rl_ovf : bif.t1_ovf);
	// [R12] fixed 64 or 32 divide
	assign pre_last = (bif.fixed_rate | bif.use_reload) ? (bif.rate_double ? 2'h1 : 2'h3)
		: (bif.rate_double ? 2'h0 : 2'h1);

	// ----------------------------------------
	// reload generator, overflows every 1024 - reload cycles
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rl_cnt <= `SPM_RELOAD_RST;
		end else if (bif.run) begin
			rl_cnt <= rl_ovf ? bif.reload : rl_cnt + 10'h001;
		end
	end

	// ----------------------------------------
	// sixteen-times oversampling tick
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pre_cnt <= 2'h0;
			bif.os_tick <= 1'b0;
		end else if (bif.run) begin
			bif.os_tick <= 1'b0;
			if (src) begin
				if (pre_cnt >= pre_last) begin
					pre_cnt <= 2'h0;
					bif.os_tick <= 1'b1;
				end else begin
					pre_cnt <= pre_cnt + 2'h1;
				end
			end
		end
	end

	// ----------------------------------------
	// shift clock half period for the synchronous mode
	// ----------------------------------------
	// [R5] twelve cycles per bit
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			half_cnt <= 4'h0;
			bif.half_tick <= 1'b0;
		end else if (bif.run) begin
			if (half_cnt == M0_HALF_LAST) begin
				half_cnt <= 4'h0;
				bif.half_tick <= 1'b1;
			end else begin
				half_cnt <= half_cnt + 4'h1;
				bif.half_tick <= 1'b0;
			end
		end
	end

endmodule

// >>> spm_baud_if.sv
`timescale 1ns/1ps
interface spm_baud_if;
	logic run;
	logic fixed_rate;
	logic rate_double;
	logic use_reload;
	logic [9:0] reload;
	logic t1_ovf;
	logic os_tick;
	logic half_tick;

	modport ctl (output run, output fixed_rate, output rate_double, output use_reload, output reload,
		output t1_ovf, input os_tick, input half_tick);
	modport gen (input run, input fixed_rate, input rate_double, input use_reload, input reload,
		input t1_ovf, output os_tick, output half_tick);
endinterface

// >>> spm_consts.svh
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SPM_ADDR_CTRL 12'h000
`define SPM_ADDR_DATA 12'h004
`define SPM_ADDR_CFG 12'h008
`define SPM_ADDR_RELOAD 12'h00c

// ----------------------------------------
// control register fields
// ----------------------------------------
`define SPM_CTRL_MODE_HI 7
`define SPM_CTRL_MODE_LO 6
`define SPM_CTRL_MULTI 5
`define SPM_CTRL_ENABLE 4
`define SPM_CTRL_TX9 3
`define SPM_CTRL_RX9 2
`define SPM_CTRL_TXF 1
`define SPM_CTRL_RXF 0

// ----------------------------------------
// configuration register fields
// ----------------------------------------
`define SPM_CFG_DOUBLE 0
`define SPM_CFG_RELOAD_SEL 1
`define SPM_CFG_OPEN_DRAIN 2
`define SPM_CFG_TX_IE 3
`define SPM_CFG_RX_IE 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define SPM_CTRL_RST 8'h00
`define SPM_CFG_RST 5'h00
`define SPM_RELOAD_RST 10'h000

// ----------------------------------------
// timing counts
// ----------------------------------------
`define SPM_M0_DIV 12
`define SPM_RELOAD_TOP 10'h3ff
`define SPM_OS_LAST 4'hf
`define SPM_OS_MID 4'h7
`define SPM_BITS8_LAST 4'h7
`define SPM_BITS9_LAST 4'h8

`endif

// >>> spm_peer.sv
`timescale 1ns/1ps
module spm_peer (
	// clock
	input logic clk_sys,
	// link
	input logic tx_wire,
	input logic rx_wire,
	input logic sync,
	output logic rx_drive
);
	logic line = 1'b1;
	logic drv = 1'b1;
	logic [7:0] mdata = 8'h00;
	logic [7:0] cap = 8'h00;
	int rcnt = 0;
	assign rx_drive = sync ? drv : line;
	// lsb first, sampled on rising shift clock
	always @(posedge tx_wire) if (sync) begin
		cap <= {rx_wire, cap[7:1]};
		rcnt <= rcnt + 1;
	end
	always @(negedge tx_wire) if (sync) drv <= mdata[rcnt[2:0]];
	task arm(input logic [7:0] m);
		mdata = m;
		drv = m[0];
		rcnt = 0;
		cap = 8'h00;
	endtask
	task send(input logic [8:0] v, input int n, input int bc);
		line <= 1'b0;
		repeat (bc) @(posedge clk_sys);
		for (int i = 0; i < n; i++) begin
			line <= v[i];
			repeat (bc) @(posedge clk_sys);
		end
		line <= 1'b1;
		repeat (bc) @(posedge clk_sys);
	endtask
	// samples mid bit, so a wrong bit time garbles the frame
	task recv(input int n, input int bc, output logic [9:0] v);
		v = 10'h000;
		@(negedge tx_wire);
		repeat (bc + bc / 2) @(posedge clk_sys);
		for (int i = 0; i <= n; i++) begin
			v[i] = tx_wire;
			if (i < n) repeat (bc) @(posedge clk_sys);
		end
	endtask
endmodule

// >>> spm_pkg.sv
package spm_pkg;

	typedef enum logic [1:0] {
		spm_mode_sync = 2'h0,
		spm_mode_async8 = 2'h1,
		spm_mode_async9_fixed = 2'h2,
		spm_mode_async9_var = 2'h3
	} spm_mode_t;

	typedef enum logic [4:0] {
		spm_tx_idle = 5'h01,
		spm_tx_start = 5'h02,
		spm_tx_data = 5'h04,
		spm_tx_stop = 5'h08,
		spm_tx_shift = 5'h10
	} spm_tx_state_t;

	typedef enum logic [3:0] {
		spm_rx_idle = 4'h1,
		spm_rx_start = 4'h2,
		spm_rx_data = 4'h4,
		spm_rx_stop = 4'h8
	} spm_rx_state_t;

endpackage

// >>> spm_top.sv
`timescale 1ns/1ps
`include "spm_consts.svh"
// Overview of operation
// [R1] Four modes: one synchronous shifter, three asynchronous with 8 or 9 data bits.
// [R2] Mode field 00 synchronous, 01 mode 1, 10 mode 2, 11 mode 3.
// [R3] Synchronous mode: transmit pin carries the shift clock in both directions.
// [R4] Synchronous mode: receive pin carries eight data bits, LSB first, both ways.
// [R5] Synchronous shift rate is the system clock divided by twelve.
// [R6] Synchronous mode: transmit flag sets after the eighth bit is sent.
// [R7] Synchronous receive starts when enabled and software clears a set receive flag.
// [R8] Asynchronous frame: start bit, 8 or 9 data bits, one stop bit.
// [R9] Writing the data buffer transmits; received data is read from it.
// [R10] Ninth transmit bit from a control bit; ninth received bit stored separately.
// [R11] Modes 1 and 3 take rate from reload generator or timer overflow.
// [R12] Mode 2 rate is clock/64, or clock/32 with the doubling bit set.
// [R13] Async transmit flag sets at stop start; receive flag mid stop bit.
// [R14] Flags are request and status; only software writes clear them.
// [R15] Separate enables gate the transmit and receive requests.
// [R16] Open-drain bit makes both pins open-drain, otherwise push-pull.
// [R17] Disabled port hands both pins back to their general purpose state.
// [R18] Software sets pins high and directions before using the port.
// [R19] Full duplex operation at rates up to 500 kHz.
// [R20] Enable low stops the engines and blocks the other registers.
// [R21] Asynchronous transmit line idles high between frames.
module spm_top (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// timer 1 overflow pulse
	input wire logic t1_ovf,
	// general purpose pin state used while disabled
	input wire logic gpio_tx_out,
	input wire logic gpio_tx_oe,
	input wire logic gpio_rx_out,
	input wire logic gpio_rx_oe,
	// serial pins
	input wire logic serial_rx_pin_in,
	output logic serial_tx_pin_out,
	output logic serial_tx_pin_oe,
	output logic serial_rx_pin_out,
	output logic serial_rx_pin_oe,
	// requests
	output logic tx_irq,
	output logic rx_irq
);

	// ----------------------------------------
	// registers and shared signals
	// ----------------------------------------
	logic mode_select_hi;
	logic mode_select_lo;
	logic multi_enable;
	logic port_module_enable;
	logic tx_ninth_bit;
	logic rx_ninth_bit;
	logic tx_complete_flag;
	logic rx_complete_flag;
	logic rate_double_bit;
	logic reload_sel;
	logic open_drain_select;
	logic tx_irq_enable;
	logic rx_irq_enable;
	logic [9:0] reload_value;
	logic [7:0] serial_data_buffer;
	spm_pkg::spm_mode_t mode;
	logic run;
	logic acc;
	logic commit;
	logic is_ctrl;
	logic is_data;
	logic is_cfg;
	logic is_reload;
	logic blocked;
	logic wr_ctrl;
	logic wr_data;
	logic wr_cfg;
	logic wr_reload;
	logic [31:0] rd_value;
	logic [7:0] ctrl_value;
	logic tx_set;
	logic rx_set;
	logic m0_rx_go;
	logic m0_rx_done;
	logic [3:0] last_bit;
	spm_pkg::spm_tx_state_t tx_state;
	logic [3:0] tx_os;
	logic [3:0] tx_bit;
	logic [8:0] tx_shift;
	logic tx_level;
	logic sclk;
	logic m0_dir_rx;
	logic m0_data;
	spm_pkg::spm_rx_state_t rx_state;
	logic [3:0] rx_os;
	logic [3:0] rx_bit;
	logic [8:0] rx_shift;
	logic rx_meta;
	logic rx_sync;
	logic rx_prev;
	logic rx_fall;
	logic [7:0] rx_byte;
	logic rx_ninth_value;
	logic tx_line;
	logic rx_drive;

	// [R1] [R2] four-mode field decode
	assign mode = spm_pkg::spm_mode_t'({mode_select_hi, mode_select_lo});
	// [R20] engines halt while disabled
	assign run = clk_en & port_module_enable;
	// [R8] eight or nine data bits
	assign last_bit = mode[1] ? `SPM_BITS9_LAST : `SPM_BITS8_LAST;

	// ----------------------------------------
	// rate generator
	// ----------------------------------------
	spm_baud_if bif ();
	assign bif.run = run;
	assign bif.fixed_rate = (mode == spm_pkg::spm_mode_async9_fixed);
	assign bif.rate_double = rate_double_bit;
	assign bif.use_reload = reload_sel;
	assign bif.reload = reload_value;
	assign bif.t1_ovf = t1_ovf;

	spm_baud u_baud (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.bif(bif)
	);

	// ----------------------------------------
	// apb decode, one wait state on every access
	// ----------------------------------------
	assign acc = psel & penable & ~pready;
	assign commit = psel & penable & pready;
	assign is_ctrl = (paddr == `SPM_ADDR_CTRL);
	assign is_data = (paddr == `SPM_ADDR_DATA);
	assign is_cfg = (paddr == `SPM_ADDR_CFG);
	assign is_reload = (paddr == `SPM_ADDR_RELOAD);
	// [R20] only control stays reachable while disabled
	assign blocked = ~port_module_enable & ~is_ctrl;
	assign wr_ctrl = commit & pwrite & is_ctrl;
	assign wr_data = commit & pwrite & is_data & port_module_enable;
	assign wr_cfg = commit & pwrite & is_cfg & port_module_enable;
	assign wr_reload = commit & pwrite & is_reload & port_module_enable;
	assign ctrl_value = {mode_select_hi, mode_select_lo, multi_enable, port_module_enable,
		tx_ninth_bit, rx_ninth_bit, tx_complete_flag, rx_complete_flag};

	always_comb begin
		rd_value = 32'h0;
		if (!blocked) begin
			case (paddr)
				`SPM_ADDR_CTRL: rd_value = {24'h0, ctrl_value};
				// [R9] received byte read back here
				`SPM_ADDR_DATA: rd_value = {24'h0, serial_data_buffer};
				`SPM_ADDR_CFG: rd_value = {27'h0, rx_irq_enable, tx_irq_enable, open_drain_select,
					reload_sel, rate_double_bit};
				`SPM_ADDR_RELOAD: rd_value = {22'h0, reload_value};
				default: rd_value = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= acc;
			if (acc) begin
				prdata <= rd_value;
				pslverr <= ~(is_ctrl | is_data | is_cfg | is_reload) | blocked;
			end
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			{mode_select_hi, mode_select_lo, multi_enable, port_module_enable, tx_ninth_bit} <= 5'h00;
			{rx_irq_enable, tx_irq_enable, open_drain_select, reload_sel, rate_double_bit} <= `SPM_CFG_RST;
			reload_value <= `SPM_RELOAD_RST;
		end else if (clk_en) begin
			if (wr_ctrl) begin
				mode_select_hi <= pwdata[`SPM_CTRL_MODE_HI];
				mode_select_lo <= pwdata[`SPM_CTRL_MODE_LO];
				multi_enable <= pwdata[`SPM_CTRL_MULTI];
				port_module_enable <= pwdata[`SPM_CTRL_ENABLE];
				tx_ninth_bit <= pwdata[`SPM_CTRL_TX9];
			end
			if (wr_cfg) begin
				{rx_irq_enable, tx_irq_enable, open_drain_select, reload_sel, rate_double_bit} <= pwdata[4:0];
			end
			if (wr_reload) begin
				reload_value <= pwdata[9:0];
			end
		end
	end

	// ----------------------------------------
	// completion flags; a set in the clearing cycle wins
	// ----------------------------------------
	// [R7] clearing a set flag starts a shift-in
	assign m0_rx_go = wr_ctrl & ~pwdata[`SPM_CTRL_RXF] & rx_complete_flag & port_module_enable
		& (mode == spm_pkg::spm_mode_sync);

	// [R14] software clear only
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tx_complete_flag <= 1'b0;
			rx_complete_flag <= 1'b0;
		end else if (clk_en) begin
			if (tx_set) begin
				tx_complete_flag <= 1'b1;
			end else if (wr_ctrl & ~pwdata[`SPM_CTRL_TXF]) begin
				tx_complete_flag <= 1'b0;
			end
			if (rx_set) begin
				rx_complete_flag <= 1'b1;
			end else if (wr_ctrl & ~pwdata[`SPM_CTRL_RXF]) begin
				rx_complete_flag <= 1'b0;
			end
		end
	end

	// [R15] per direction enables
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tx_irq <= 1'b0;
			rx_irq <= 1'b0;
		end else if (clk_en) begin
			tx_irq <= tx_complete_flag & tx_irq_enable;
			rx_irq <= rx_complete_flag & rx_irq_enable;
		end
	end

	// ----------------------------------------
	// transmitter and synchronous shifter
	// ----------------------------------------
	// [R19] a busy shifter ignores new buffer writes; rate set by software
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tx_state <= spm_pkg::spm_tx_idle;
			tx_os <= 4'h0;
			tx_bit <= 4'h0;
			tx_shift <= 9'h000;
			tx_level <= 1'b1;
			sclk <= 1'b1;
			m0_dir_rx <= 1'b0;
			m0_data <= 1'b1;
			tx_set <= 1'b0;
			m0_rx_done <= 1'b0;
		end else if (run) begin
			tx_set <= 1'b0;
			m0_rx_done <= 1'b0;
			unique case (tx_state)
				spm_pkg::spm_tx_idle: begin
					// [R21] idle high
					tx_level <= 1'b1;
					sclk <= 1'b1;
					tx_os <= 4'h0;
					tx_bit <= 4'h0;
					// [R9] buffer write starts sending
					if (wr_data) begin
						// [R10] ninth bit from control
						tx_shift <= {tx_ninth_bit, pwdata[7:0]};
						if (mode == spm_pkg::spm_mode_sync) begin
							tx_state <= spm_pkg::spm_tx_shift;
							m0_dir_rx <= 1'b0;
							m0_data <= pwdata[0];
						end else begin
							tx_state <= spm_pkg::spm_tx_start;
							tx_level <= 1'b0;
						end
					end else if (m0_rx_go) begin
						tx_state <= spm_pkg::spm_tx_shift;
						m0_dir_rx <= 1'b1;
					end
				end
				// [R8] start, data, stop
				spm_pkg::spm_tx_start: begin
					if (bif.os_tick) begin
						tx_os <= tx_os + 4'h1;
						if (tx_os == `SPM_OS_LAST) begin
							tx_state <= spm_pkg::spm_tx_data;
							tx_level <= tx_shift[0];
						end
					end
				end
				spm_pkg::spm_tx_data: begin
					if (bif.os_tick) begin
						tx_os <= tx_os + 4'h1;
						if (tx_os == `SPM_OS_LAST) begin
							tx_bit <= tx_bit + 4'h1;
							tx_shift <= {1'b0, tx_shift[8:1]};
							if (tx_bit == last_bit) begin
								tx_state <= spm_pkg::spm_tx_stop;
								tx_level <= 1'b1;
								// [R13] flag at stop bit start
								tx_set <= 1'b1;
							end else begin
								tx_level <= tx_shift[1];
							end
						end
					end
				end
				spm_pkg::spm_tx_stop: begin
					if (bif.os_tick) begin
						tx_os <= tx_os + 4'h1;
						if (tx_os == `SPM_OS_LAST) begin
							tx_state <= spm_pkg::spm_tx_idle;
						end
					end
				end
				spm_pkg::spm_tx_shift: begin
					if (bif.half_tick) begin
						sclk <= ~sclk;
						if (sclk) begin
							// falling edge presents the next bit
							if (tx_bit != 4'h0) begin
								m0_data <= tx_shift[0];
							end
						end else begin
							// [R4] rising edge samples, LSB first
							tx_shift <= {1'b0, rx_sync, tx_shift[7:1]};
							tx_bit <= tx_bit + 4'h1;
							if (tx_bit == `SPM_BITS8_LAST) begin
								tx_state <= spm_pkg::spm_tx_idle;
								// [R6] flag after eighth bit
								tx_set <= ~m0_dir_rx;
								// [R7] flag after eighth bit in
								m0_rx_done <= m0_dir_rx;
							end
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// receive pin synchroniser
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			rx_prev <= 1'b1;
		end else if (clk_en) begin
			rx_meta <= serial_rx_pin_in;
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
		end
	end
	assign rx_fall = rx_prev & ~rx_sync;

	// ----------------------------------------
	// asynchronous receiver
	// ----------------------------------------
	// in 8-bit mode the data sits one place higher and the stop bit is kept as ninth bit
	assign rx_byte = mode[1] ? rx_shift[7:0] : rx_shift[8:1];
	assign rx_ninth_value = mode[1] ? rx_shift[8] : rx_sync;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rx_state <= spm_pkg::spm_rx_idle;
			rx_os <= 4'h0;
			rx_bit <= 4'h0;
			rx_shift <= 9'h000;
			serial_data_buffer <= 8'h00;
			rx_ninth_bit <= 1'b0;
			rx_set <= 1'b0;
		end else if (run) begin
			rx_set <= 1'b0;
			if (m0_rx_done) begin
				serial_data_buffer <= tx_shift[7:0];
				rx_set <= 1'b1;
			end
			unique case (rx_state)
				spm_pkg::spm_rx_idle: begin
					rx_os <= 4'h0;
					rx_bit <= 4'h0;
					if (rx_fall && mode != spm_pkg::spm_mode_sync) begin
						rx_state <= spm_pkg::spm_rx_start;
					end
				end
				spm_pkg::spm_rx_start: begin
					if (bif.os_tick) begin
						rx_os <= rx_os + 4'h1;
						if (rx_os == `SPM_OS_MID) begin
							// a glitch shorter than half a bit is not a start
							rx_state <= rx_sync ? spm_pkg::spm_rx_idle : spm_pkg::spm_rx_data;
							rx_os <= 4'h0;
						end
					end
				end
				spm_pkg::spm_rx_data: begin
					if (bif.os_tick) begin
						rx_os <= rx_os + 4'h1;
						if (rx_os == `SPM_OS_LAST) begin
							rx_shift <= {rx_sync, rx_shift[8:1]};
							rx_bit <= rx_bit + 4'h1;
							if (rx_bit == last_bit) begin
								rx_state <= spm_pkg::spm_rx_stop;
							end
						end
					end
				end
				spm_pkg::spm_rx_stop: begin
					if (bif.os_tick) begin
						rx_os <= rx_os + 4'h1;
						if (rx_os == `SPM_OS_LAST) begin
							rx_state <= spm_pkg::spm_rx_idle;
							serial_data_buffer <= rx_byte;
							// [R10] ninth bit kept apart
							rx_ninth_bit <= rx_ninth_value;
							// [R13] flag mid stop bit
							rx_set <= ~(multi_enable & mode[1] & ~rx_ninth_value);
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	// [R3] shift clock on transmit pin
	assign tx_line = (mode == spm_pkg::spm_mode_sync) ? sclk : tx_level;
	// keep data on the pin through the last rising clock, the far end samples there
	assign rx_drive = ((tx_state == spm_pkg::spm_tx_shift) & ~m0_dir_rx) | (tx_set & ~|mode);

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			serial_tx_pin_out <= 1'b0;
			serial_tx_pin_oe <= 1'b0;
			serial_rx_pin_out <= 1'b0;
			serial_rx_pin_oe <= 1'b0;
		end else if (clk_en) begin
			if (!port_module_enable) begin
				// [R17] back to general purpose
				serial_tx_pin_out <= gpio_tx_out;
				serial_tx_pin_oe <= gpio_tx_oe;
				serial_rx_pin_out <= gpio_rx_out;
				serial_rx_pin_oe <= gpio_rx_oe;
			end else begin
				// [R16] open-drain drives low only
				serial_tx_pin_out <= tx_line;
				serial_tx_pin_oe <= open_drain_select ? ~tx_line : 1'b1;
				serial_rx_pin_out <= rx_drive & m0_data;
				serial_rx_pin_oe <= rx_drive & (open_drain_select ? ~m0_data : 1'b1);
			end
		end
	end

endmodule

// >>> spm_top_props.sv
`timescale 1ns/1ps
`include "spm_consts.svh"
module spm_top_props (
	// clock and reset
	input logic clk_sys,
	input logic reset_n,
	input logic clk_en,
	// apb
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	// pins and requests
	input logic gpio_tx_out,
	input logic gpio_tx_oe,
	input logic gpio_rx_out,
	input logic gpio_rx_oe,
	input logic serial_tx_pin_out,
	input logic serial_tx_pin_oe,
	input logic serial_rx_pin_out,
	input logic serial_rx_pin_oe,
	input logic tx_irq,
	input logic rx_irq
);
	// ----------------
	// shadow of software settings
	// ----------------
	logic [7:0] ctl;
	logic [4:0] cfg;
	logic [1:0] st;
	wire wr = psel && penable && pready && pwrite && !pslverr;
	// three quiet cycles after any write, so the registered pins never trip a check
	wire ok = clk_en && st == 2'h3;
	wire en = ctl[`SPM_CTRL_ENABLE];
	wire [3:0] gp = {gpio_tx_out, gpio_tx_oe, gpio_rx_out, gpio_rx_oe};
	wire [3:0] pins = {serial_tx_pin_out, serial_tx_pin_oe, serial_rx_pin_out, serial_rx_pin_oe};
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ctl <= 8'h00;
		end else if (wr && paddr == `SPM_ADDR_CTRL) begin
			ctl <= pwdata[7:0];
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cfg <= 5'h00;
		end else if (wr && paddr == `SPM_ADDR_CFG) begin
			cfg <= pwdata[4:0];
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st <= 2'h0;
		end else if (wr) begin
			st <= 2'h0;
		end else if (clk_en && st != 2'h3) begin
			st <= st + 2'h1;
		end
	end
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	sequence s_take;
		psel && penable && !pready && clk_en;
	endsequence
	sequence s_low6;
		(!serial_tx_pin_out) [*6] ##1 serial_tx_pin_out;
	endsequence
	// ----------------
	// assertions
	// ----------------
	a_apb_answer: assert property (s_take |=> pready)
		else $error("apb access not answered after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_blocked_err: assert property (psel && pready && !en && paddr != `SPM_ADDR_CTRL |-> pslverr && prdata == 32'h0)
		else $error("blocked register answered while disabled");
	a_gpio_follow: assert property (ok && !en && $past(clk_en) |-> pins == $past(gp))
		else $error("disabled pins do not follow gpio state");
	a_open_drain: assert property (ok && en && cfg[`SPM_CFG_OPEN_DRAIN] |-> serial_tx_pin_oe == !serial_tx_pin_out)
		else $error("open drain transmit pin drives high");
	a_push_pull: assert property (ok && en && !cfg[`SPM_CFG_OPEN_DRAIN] |-> serial_tx_pin_oe)
		else $error("push pull transmit pin not driven");
	a_tx_gate: assert property (ok && !cfg[`SPM_CFG_TX_IE] |-> !tx_irq)
		else $error("transmit request while disabled");
	a_rx_gate: assert property (ok && !cfg[`SPM_CFG_RX_IE] |-> !rx_irq)
		else $error("receive request while disabled");
	a_sync_half: assert property (ok && en && ctl[7:6] == 2'h0 && $fell(serial_tx_pin_out) |-> s_low6)
		else $error("shift clock low phase not six cycles");
endmodule

// >>> tb_serial_port_four_mode.sv
`timescale 1ns/1ps
`include "spm_consts.svh"
module tb_serial_port_four_mode;
	logic clk_sys, reset_n, clk_en, psel, penable, pwrite, t1_ovf, pready, pslverr, e, t9, sync;
	logic gpio_tx_out, gpio_tx_oe, gpio_rx_out, gpio_rx_oe, peer_rx;
	logic serial_tx_pin_out, serial_tx_pin_oe, serial_rx_pin_out, serial_rx_pin_oe, tx_irq, rx_irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] d;
	logic [8:0] r;
	logic [9:0] got;
	logic [1:0] tm [4];
	logic [4:0] tc [4];
	int mismatches, num_checks, cyc, bc, nb;
	// transmit line carries a pull-up; the peer drives the released receive line
	wire tx_wire = serial_tx_pin_oe ? serial_tx_pin_out : 1'b1;
	wire rx_wire = serial_rx_pin_oe ? serial_rx_pin_out : peer_rx;
	wire [3:0] pins = {serial_tx_pin_out, serial_tx_pin_oe, serial_rx_pin_out, serial_rx_pin_oe};
	wire [3:0] gp = {gpio_tx_out, gpio_tx_oe, gpio_rx_out, gpio_rx_oe};
	spm_top dut (.clk_sys, .reset_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .t1_ovf, .gpio_tx_out, .gpio_tx_oe, .gpio_rx_out, .gpio_rx_oe, .serial_rx_pin_in(rx_wire),
		.serial_tx_pin_out, .serial_tx_pin_oe, .serial_rx_pin_out, .serial_rx_pin_oe, .tx_irq, .rx_irq);
	spm_peer peer (.clk_sys, .tx_wire, .rx_wire, .sync, .rx_drive(peer_rx));
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// timer overflow every four cycles; also the hang limit
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		t1_ovf <= (cyc % 4 == 0);
		if (cyc == 20000) begin
			mismatches++;
			complete_run;
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task wait_irq(input logic tx);
		int i;
		repeat (2) @(posedge clk_sys);
		for (i = 0; i < 5000 && (tx ? tx_irq : rx_irq) !== 1'b1; i++) @(posedge clk_sys);
	endtask
	task complete_run;
		if (mismatches == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	function automatic logic [31:0] ctrl(logic [1:0] m, logic b9, logic [1:0] fl);
		return {24'h0, m, 2'h1, b9, 1'b0, fl};
	endfunction
	function automatic int bit_cyc(logic [1:0] m, logic [4:0] c);
		if (m == 2'h2) return c[`SPM_CFG_DOUBLE] ? 32 : 64;
		if (c[`SPM_CFG_RELOAD_SEL]) return (64 * (1024 - 1022)) >> c[`SPM_CFG_DOUBLE];
		return (32 * 4) >> c[`SPM_CFG_DOUBLE];
	endfunction
	function automatic logic [9:0] exp_frame(logic [1:0] m, logic b9, logic [7:0] v);
		return (m == 2'h1) ? {2'h1, v} : {1'b1, b9, v};
	endfunction
	initial begin
		{clk_en, psel, penable, pwrite, paddr, pwdata, sync, reset_n} = 50'h2_0000_0000_0000;
		{gpio_tx_out, gpio_tx_oe, gpio_rx_out, gpio_rx_oe, mismatches, num_checks, cyc} = '0;
		tm = '{2'h2, 2'h2, 2'h1, 2'h3};
		tc = '{5'h18, 5'h1d, 5'h12, 5'h19};
		void'($urandom(48));
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		apb(1'b1, `SPM_ADDR_CFG, 32'h1f);
		chk(e, 1);
		apb(1'b0, `SPM_ADDR_CTRL, 32'h0);
		chk(rd, 32'h0);
		repeat (4) begin
			{gpio_tx_out, gpio_tx_oe, gpio_rx_out, gpio_rx_oe} <= 4'($urandom);
			repeat (2) @(posedge clk_sys);
			chk(pins, gp);
		end
		// transmit pin out high, receive pin input
		{gpio_tx_out, gpio_tx_oe, gpio_rx_out, gpio_rx_oe} <= 4'he;
		apb(1'b1, `SPM_ADDR_CTRL, ctrl(2'h0, 1'b0, 2'h0));
		apb(1'b0, `SPM_ADDR_CFG, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk({e, rd[30:0]}, 32'h80000000);
		apb(1'b1, `SPM_ADDR_RELOAD, 32'h3fe);
		for (int k = 0; k < 4; k++) begin
			{t9, r, d} = 18'($urandom);
			if (k == 1) r[8] = 1'b0;
			apb(1'b1, `SPM_ADDR_CTRL, ctrl(tm[k], t9, 2'h0) | (32'(k == 1) << `SPM_CTRL_MULTI));
			apb(1'b1, `SPM_ADDR_CFG, 32'(tc[k]));
			chk(rx_irq, 0);
			bc = bit_cyc(tm[k], tc[k]);
			nb = (tm[k] == 2'h1) ? 8 : 9;
			chk(tx_wire, 1);
			fork
				apb(1'b1, `SPM_ADDR_DATA, 32'(d));
				begin
					peer.recv(nb, bc, got);
					chk(tx_irq, tc[k][`SPM_CFG_TX_IE]);
				end
				begin
					@(posedge clk_sys);
					peer.send(r, nb, bc);
				end
			join
			chk(got, exp_frame(tm[k], t9, d));
			if (k != 1) wait_irq(1'b0);
			chk(rx_irq, k != 1);
			apb(1'b0, `SPM_ADDR_DATA, 32'h0);
			chk(rd, 32'(r[7:0]));
			apb(1'b0, `SPM_ADDR_CTRL, 32'h0);
			chk(rd[3:0], {t9, (tm[k] == 2'h1) ? 1'b1 : r[8], 1'b1, k != 1});
		end
		apb(1'b1, `SPM_ADDR_CTRL, ctrl(2'h0, 1'b0, 2'h3));
		d = 8'($urandom);
		peer.arm(d);
		sync <= 1'b1;
		apb(1'b1, `SPM_ADDR_CTRL, ctrl(2'h0, 1'b0, 2'h2));
		wait_irq(1'b0);
		apb(1'b0, `SPM_ADDR_DATA, 32'h0);
		chk(rd, 32'(d));
		d = 8'h80;
		peer.arm(d);
		apb(1'b1, `SPM_ADDR_CTRL, ctrl(2'h0, 1'b0, 2'h1));
		apb(1'b1, `SPM_ADDR_DATA, 32'(d));
		wait_irq(1'b1);
		chk(peer.cap, d);
		apb(1'b1, `SPM_ADDR_CTRL, 32'h0);
		sync <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(pins, gp);
		complete_run;
	end
endmodule
bind spm_top spm_top_props props (.clk_sys, .reset_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .gpio_tx_out, .gpio_tx_oe, .gpio_rx_out, .gpio_rx_oe, .serial_tx_pin_out,
	.serial_tx_pin_oe, .serial_rx_pin_out, .serial_rx_pin_oe, .tx_irq, .rx_irq);
